// *** hdl/ocrs_pkg.sv ***
package ocrs_pkg;

  // core clock and the two low fixed rates, in hertz
  localparam int OCRS_CLK_HZ     = 125_000_000;
  localparam int OCRS_RATE_2K_HZ = 2000;
  localparam int OCRS_RATE_8K_HZ = 8000;
  // full output period of each low rate in core clock cycles
  localparam int OCRS_PERIOD_2K_CYC = OCRS_CLK_HZ / OCRS_RATE_2K_HZ;
  localparam int OCRS_PERIOD_8K_CYC = OCRS_CLK_HZ / OCRS_RATE_8K_HZ;
  localparam int OCRS_LOW_CNT_W     = 16;

  // register indices; the byte address is four times the index
  localparam logic [7:0] OCRS_IDX_SELECT_A = 8'h60;
  localparam logic [7:0] OCRS_IDX_SELECT_B = 8'h61;
  localparam logic [7:0] OCRS_IDX_SELECT_C = 8'h62;
  localparam logic [7:0] OCRS_IDX_STATUS   = 8'h70;

  // reset values of the select registers
  localparam logic [7:0] OCRS_RST_SELECT_A = 8'h01;
  localparam logic [7:0] OCRS_RST_SELECT_B = 8'h86;
  localparam logic [7:0] OCRS_RST_SELECT_C = 8'h8a;

  // field layout: low nibble odd output, high nibble even output
  localparam int OCRS_SEL_W    = 4;
  localparam int OCRS_NUM_OUT  = 6;
  localparam int OCRS_NUM_CODE = 16;
  localparam int OCRS_LO_LSB   = 0;
  localparam int OCRS_HI_LSB   = 4;

  // status register layout
  localparam int OCRS_STAT_PIN_LSB  = 0;
  localparam int OCRS_STAT_BUSY_LSB = 8;

  // rate select codes
  localparam logic [3:0] OCRS_SEL_OFF     = 4'h0;
  localparam logic [3:0] OCRS_SEL_2K      = 4'h1;
  localparam logic [3:0] OCRS_SEL_8K      = 4'h2;
  localparam logic [3:0] OCRS_SEL_SYNTH_B = 4'h3;
  localparam logic [3:0] OCRS_SEL_SYNTH_A = 4'h4;
  localparam logic [3:0] OCRS_SEL_MAIN_48 = 4'h5;
  localparam logic [3:0] OCRS_SEL_MAIN_16 = 4'h6;
  localparam logic [3:0] OCRS_SEL_MAIN_12 = 4'h7;
  localparam logic [3:0] OCRS_SEL_MAIN_8  = 4'h8;
  localparam logic [3:0] OCRS_SEL_MAIN_6  = 4'h9;
  localparam logic [3:0] OCRS_SEL_MAIN_4  = 4'ha;
  localparam logic [3:0] OCRS_SEL_SEC_64  = 4'hb;
  localparam logic [3:0] OCRS_SEL_SEC_48  = 4'hc;
  localparam logic [3:0] OCRS_SEL_SEC_16  = 4'hd;
  localparam logic [3:0] OCRS_SEL_SEC_8   = 4'he;
  localparam logic [3:0] OCRS_SEL_SEC_4   = 4'hf;

  // outputs with their own code variants
  localparam int OCRS_OUT_SEC_HALF  = 4;
  localparam int OCRS_OUT_MAIN_FAST = 6;

  // pll edge divider: every divisor divides the wrap count
  localparam int         OCRS_NUM_DIV  = 8;
  localparam int         OCRS_DIV_CNT_W = 8;
  localparam logic [7:0] OCRS_DIV_WRAP = 8'hbf;
  localparam int         OCRS_DIV_VALUE [OCRS_NUM_DIV] = '{2, 4, 6, 8, 12, 16, 48, 64};
  localparam int OCRS_DIX_2  = 0;
  localparam int OCRS_DIX_4  = 1;
  localparam int OCRS_DIX_6  = 2;
  localparam int OCRS_DIX_8  = 3;
  localparam int OCRS_DIX_12 = 4;
  localparam int OCRS_DIX_16 = 5;
  localparam int OCRS_DIX_48 = 6;
  localparam int OCRS_DIX_64 = 7;

  // external asynchronous inputs passing the synchroniser
  localparam int OCRS_NUM_ASYNC = 4;
  localparam int OCRS_AIN_MAIN  = 0;
  localparam int OCRS_AIN_SEC   = 1;
  localparam int OCRS_AIN_SYN_A = 2;
  localparam int OCRS_AIN_SYN_B = 3;

  // ahb-lite encodings
  localparam logic [1:0] OCRS_HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] OCRS_HSIZE_WORD    = 3'b010;
  localparam logic       OCRS_HRESP_OKAY    = 1'b0;
  localparam int         OCRS_IDX_LSB       = 2;
  localparam int         OCRS_IDX_MSB       = 9;

  // output switch states
  typedef enum logic [2:0] {
    OCRS_ST_FOLLOW = 3'b001,
    OCRS_ST_DRAIN  = 3'b010,
    OCRS_ST_ARM    = 3'b100
  } ocrs_switch_state_t;

endpackage

// *** hdl/ocrs_pll_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
module ocrs_pll_divider
  import ocrs_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic                    srcRise,
  output logic [OCRS_NUM_DIV-1:0]      divClk
);

  logic [OCRS_DIV_CNT_W-1:0] edgeCnt_q;
  logic [OCRS_DIV_CNT_W-1:0] edgeCnt_d;
  logic [OCRS_NUM_DIV-1:0]   divClk_q;

  // half-period test: high for the first half of each divisor cycle
  function automatic logic divLevel(input logic [OCRS_DIV_CNT_W-1:0] cnt, input int n);
    logic [OCRS_DIV_CNT_W-1:0] nv;
    nv = OCRS_DIV_CNT_W'(n);
    return (cnt % nv) < (nv >> 1);
  endfunction

  // one shared count keeps all divided clocks phase aligned
  always_comb begin
    edgeCnt_d = edgeCnt_q;
    if (srcRise) begin
      edgeCnt_d = (edgeCnt_q == OCRS_DIV_WRAP) ? '0 : edgeCnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      edgeCnt_q <= '0;
    end else begin
      edgeCnt_q <= edgeCnt_d;
    end
  end

  // divided levels, registered so they never glitch
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      divClk_q <= '0;
    end else begin
      for (int i = 0; i < OCRS_NUM_DIV; i++) begin
        divClk_q[i] <= divLevel(edgeCnt_d, OCRS_DIV_VALUE[i]);
      end
    end
  end

  assign divClk = divClk_q;

endmodule
`default_nettype wire

// *** hdl/ocrs_safe_switch.sv ***
`timescale 1ns/1ps
`default_nettype none
module ocrs_safe_switch
  import ocrs_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire logic [OCRS_SEL_W-1:0]    rateSel,
  input  wire logic [OCRS_NUM_CODE-1:0] cands,
  output logic                          pinOut,
  output logic                          switching
);

  ocrs_switch_state_t      state_q;
  logic [OCRS_SEL_W-1:0]   activeSel_q;
  logic                    pin_q;

  // a dead old source stuck high keeps the switch draining
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= OCRS_ST_FOLLOW;
      activeSel_q <= OCRS_SEL_OFF;
    end else begin
      case (state_q)
        OCRS_ST_FOLLOW: begin
          if (rateSel != activeSel_q) begin
            state_q <= OCRS_ST_DRAIN;
          end
        end
        OCRS_ST_DRAIN: begin
          // leave the old source only in its low phase
          if (!cands[activeSel_q]) begin
            state_q <= OCRS_ST_ARM;
          end
        end
        OCRS_ST_ARM: begin
          // join the new source only in its low phase
          if (!cands[rateSel]) begin
            activeSel_q <= rateSel;
            state_q     <= OCRS_ST_FOLLOW;
          end
        end
        default: begin
          state_q <= OCRS_ST_FOLLOW;
        end
      endcase
    end
  end

  // pin is held low while armed; code zero has a constant low candidate
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= (state_q == OCRS_ST_ARM) ? 1'b0 : cands[activeSel_q];
    end
  end

  assign pinOut    = pin_q;
  assign switching = (state_q != OCRS_ST_FOLLOW);

endmodule
`default_nettype wire

// *** hdl/ocrs_output_clock_select.sv ***
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ocrs_output_clock_select
  import ocrs_pkg::*;
#(
  parameter int PERIOD_2K_CYC = OCRS_PERIOD_2K_CYC,
  parameter int PERIOD_8K_CYC = OCRS_PERIOD_8K_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        mainPllClk,
  input  wire logic        secPllClk,
  input  wire logic        synthRateA,
  input  wire logic        synthRateB,
  output logic             clockOut1,
  output logic             clockOut2,
  output logic             clockOut3,
  output logic             clockOut4,
  output logic             clockOut5,
  output logic             clockOut6
);

  // ---- register bus state
  logic                   wrPend_q;
  logic [7:0]             wrIdx_q;
  logic                   wrHit;
  logic [31:0]            hrdata_q;
  logic [7:0]             selectA_q;
  logic [7:0]             selectA_d;
  logic [7:0]             selectB_q;
  logic [7:0]             selectB_d;
  logic [7:0]             selectC_q;
  logic [7:0]             selectC_d;
  logic                   addrPhase;
  logic                   idxOk;
  logic [7:0]             reqIdx;

  // ---- synchroniser state
  logic [OCRS_NUM_ASYNC-1:0] syncMeta_q;
  logic [OCRS_NUM_ASYNC-1:0] syncMid_q;
  logic [OCRS_NUM_ASYNC-1:0] syncLate_q;
  logic [OCRS_NUM_ASYNC-1:0] syncLvl_q;
  logic [OCRS_NUM_ASYNC-1:0] syncRise_q;

  // ---- low rate generators
  logic [OCRS_LOW_CNT_W-1:0] cnt2k_q;
  logic [OCRS_LOW_CNT_W-1:0] cnt8k_q;
  logic                      lo2k_q;
  logic                      lo8k_q;

  // ---- dividers and output switches
  logic [OCRS_NUM_DIV-1:0]   mainDiv;
  logic [OCRS_NUM_DIV-1:0]   secDiv;
  logic [OCRS_SEL_W-1:0]     rateSel   [OCRS_NUM_OUT];
  logic [OCRS_NUM_CODE-1:0]  cands     [OCRS_NUM_OUT];
  logic [OCRS_NUM_OUT-1:0]   pinLvl;
  logic [OCRS_NUM_OUT-1:0]   busy;

  // word index of a bus address; upper bits must be zero to hit
  function automatic logic indexValid(input logic [31:0] addr);
    return (addr[31:OCRS_IDX_MSB+1] == '0) && (addr[OCRS_IDX_LSB-1:0] == '0);
  endfunction

  // per-output candidate table, one entry per select code
  function automatic logic [OCRS_NUM_CODE-1:0] buildCands(
    input int                      outNum,
    input logic                    lo2k,
    input logic                    lo8k,
    input logic                    synA,
    input logic                    synB,
    input logic                    mainRaw,
    input logic [OCRS_NUM_DIV-1:0] mDiv,
    input logic [OCRS_NUM_DIV-1:0] sDiv
  );
    logic [OCRS_NUM_CODE-1:0] c;
    c                   = '0;
    c[OCRS_SEL_OFF]     = 1'b0;
    c[OCRS_SEL_2K]      = lo2k;
    c[OCRS_SEL_8K]      = lo8k;
    c[OCRS_SEL_SYNTH_A] = synA;
    c[OCRS_SEL_SYNTH_B] = (outNum == OCRS_OUT_MAIN_FAST) ? mDiv[OCRS_DIX_2] : synB;
    c[OCRS_SEL_MAIN_48] = (outNum == OCRS_OUT_MAIN_FAST) ? mainRaw : mDiv[OCRS_DIX_48];
    c[OCRS_SEL_MAIN_16] = mDiv[OCRS_DIX_16];
    c[OCRS_SEL_MAIN_12] = mDiv[OCRS_DIX_12];
    c[OCRS_SEL_MAIN_8]  = mDiv[OCRS_DIX_8];
    c[OCRS_SEL_MAIN_6]  = mDiv[OCRS_DIX_6];
    c[OCRS_SEL_MAIN_4]  = mDiv[OCRS_DIX_4];
    c[OCRS_SEL_SEC_64]  = (outNum == OCRS_OUT_SEC_HALF) ? sDiv[OCRS_DIX_2] : sDiv[OCRS_DIX_64];
    c[OCRS_SEL_SEC_48]  = sDiv[OCRS_DIX_48];
    c[OCRS_SEL_SEC_16]  = sDiv[OCRS_DIX_16];
    c[OCRS_SEL_SEC_8]   = sDiv[OCRS_DIX_8];
    c[OCRS_SEL_SEC_4]   = sDiv[OCRS_DIX_4];
    return c;
  endfunction

  // ---- ahb-lite slave, zero wait states
  assign addrPhase = hsel && hready && (htrans == OCRS_HTRANS_NONSEQ);
  assign reqIdx    = haddr[OCRS_IDX_MSB:OCRS_IDX_LSB];
  assign idxOk     = indexValid(haddr);
  assign wrHit     = wrPend_q;

  // latch the write address phase; narrower sizes are ignored
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      wrIdx_q  <= '0;
    end else begin
      wrPend_q <= addrPhase && hwrite && idxOk && (hsize == OCRS_HSIZE_WORD);
      wrIdx_q  <= reqIdx;
    end
  end

  // next register values; data arrives in the write data phase
  always_comb begin
    selectA_d = selectA_q;
    selectB_d = selectB_q;
    selectC_d = selectC_q;
    if (wrHit) begin
      case (wrIdx_q)
        OCRS_IDX_SELECT_A: selectA_d = hwdata[7:0];
        OCRS_IDX_SELECT_B: selectB_d = hwdata[7:0];
        OCRS_IDX_SELECT_C: selectC_d = hwdata[7:0];
        default: begin
          selectA_d = selectA_q;
        end
      endcase
    end
  end

  // select registers; pll and synth rates are configured outside this block
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      selectA_q <= OCRS_RST_SELECT_A;
      selectB_q <= OCRS_RST_SELECT_B;
      selectC_q <= OCRS_RST_SELECT_C;
    end else begin
      selectA_q <= selectA_d;
      selectB_q <= selectB_d;
      selectC_q <= selectC_d;
    end
  end

  // read data is taken from next values so a read right after a write sees it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q <= '0;
    end else if (addrPhase && !hwrite) begin
      hrdata_q <= '0;
      if (idxOk) begin
        case (reqIdx)
          OCRS_IDX_SELECT_A: hrdata_q[7:0] <= selectA_d;
          OCRS_IDX_SELECT_B: hrdata_q[7:0] <= selectB_d;
          OCRS_IDX_SELECT_C: hrdata_q[7:0] <= selectC_d;
          OCRS_IDX_STATUS: begin
            hrdata_q[OCRS_STAT_PIN_LSB +: OCRS_NUM_OUT]  <= pinLvl;
            hrdata_q[OCRS_STAT_BUSY_LSB +: OCRS_NUM_OUT] <= busy;
          end
          default: hrdata_q <= '0;
        endcase
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = OCRS_HRESP_OKAY;
  assign hrdata    = hrdata_q;

  // ---- field extraction, two outputs per register
  assign rateSel[0] = selectA_q[OCRS_LO_LSB +: OCRS_SEL_W];
  assign rateSel[1] = selectA_q[OCRS_HI_LSB +: OCRS_SEL_W];
  assign rateSel[2] = selectB_q[OCRS_LO_LSB +: OCRS_SEL_W];
  assign rateSel[3] = selectB_q[OCRS_HI_LSB +: OCRS_SEL_W];
  assign rateSel[4] = selectC_q[OCRS_LO_LSB +: OCRS_SEL_W];
  assign rateSel[5] = selectC_q[OCRS_HI_LSB +: OCRS_SEL_W];

  // ---- three-stage synchroniser; first stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncMeta_q <= '0;
      syncMid_q  <= '0;
      syncLate_q <= '0;
    end else begin
      syncMeta_q <= {synthRateB, synthRateA, secPllClk, mainPllClk};
      syncMid_q  <= syncMeta_q;
      syncLate_q <= syncMid_q;
    end
  end

  // a change counts only when stages two and three agree
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncLvl_q  <= '0;
      syncRise_q <= '0;
    end else begin
      for (int i = 0; i < OCRS_NUM_ASYNC; i++) begin
        syncRise_q[i] <= (syncMid_q[i] == syncLate_q[i]) && syncLate_q[i] && !syncLvl_q[i];
        if (syncMid_q[i] == syncLate_q[i]) begin
          syncLvl_q[i] <= syncLate_q[i];
        end
      end
    end
  end

  // ---- 2 khz and 8 khz from the core clock, high for the first half
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt2k_q <= '0;
      lo2k_q  <= 1'b0;
    end else begin
      cnt2k_q <= (cnt2k_q == OCRS_LOW_CNT_W'(PERIOD_2K_CYC - 1)) ? '0 : cnt2k_q + 1'b1;
      lo2k_q  <= cnt2k_q < OCRS_LOW_CNT_W'(PERIOD_2K_CYC / 2);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt8k_q <= '0;
      lo8k_q  <= 1'b0;
    end else begin
      cnt8k_q <= (cnt8k_q == OCRS_LOW_CNT_W'(PERIOD_8K_CYC - 1)) ? '0 : cnt8k_q + 1'b1;
      lo8k_q  <= cnt8k_q < OCRS_LOW_CNT_W'(PERIOD_8K_CYC / 2);
    end
  end

  // ---- pll dividers; pll must run below a quarter of the core clock
  ocrs_pll_divider u_main_div (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .srcRise  (syncRise_q[OCRS_AIN_MAIN]),
    .divClk   (mainDiv)
  );

  ocrs_pll_divider u_sec_div (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .srcRise  (syncRise_q[OCRS_AIN_SEC]),
    .divClk   (secDiv)
  );

  // ---- one glitch-free switch per output pin
  for (genvar g = 0; g < OCRS_NUM_OUT; g++) begin : g_out
    assign cands[g] = buildCands(g + 1, lo2k_q, lo8k_q,
                                 syncLvl_q[OCRS_AIN_SYN_A], syncLvl_q[OCRS_AIN_SYN_B],
                                 syncLvl_q[OCRS_AIN_MAIN], mainDiv, secDiv);

    ocrs_safe_switch u_switch (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .rateSel   (rateSel[g]),
      .cands     (cands[g]),
      .pinOut    (pinLvl[g]),
      .switching (busy[g])
    );
  end

  assign clockOut1 = pinLvl[0];
  assign clockOut2 = pinLvl[1];
  assign clockOut3 = pinLvl[2];
  assign clockOut4 = pinLvl[3];
  assign clockOut5 = pinLvl[4];
  assign clockOut6 = pinLvl[5];

endmodule
`default_nettype wire

// *** tb/ocrs_output_clock_select_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module ocrs_output_clock_select_monitor
  import ocrs_pkg::*;
#(
  parameter int PERIOD_2K_CYC = OCRS_PERIOD_2K_CYC,
  parameter int PERIOD_8K_CYC = OCRS_PERIOD_8K_CYC
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        clockOut1,
  input wire logic        clockOut2,
  input wire logic        clockOut3,
  input wire logic        clockOut4,
  input wire logic        clockOut5,
  input wire logic        clockOut6
);
  logic       wrPend_q;
  logic [7:0] shadowA_q;
  logic [9:0] offCnt_q;
  wire logic  rdReq = hsel && hready && htrans == OCRS_HTRANS_NONSEQ && !hwrite;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // word write to select a seen in its address phase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
    end else if (hready) begin
      wrPend_q <= hsel && htrans == OCRS_HTRANS_NONSEQ && hwrite &&
                  hsize == OCRS_HSIZE_WORD && haddr == 32'h180;
    end
  end
  // shadow copy of select a, landed at the end of the data phase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shadowA_q <= OCRS_RST_SELECT_A;
    end else if (hready && wrPend_q) begin
      shadowA_q <= hwdata[7:0];
    end
  end
  // cycles with output one off; 600 outlasts any old source's low wait
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      offCnt_q <= 10'h0;
    end else if (shadowA_q[3:0] != 4'h0) begin
      offCnt_q <= 10'h0;
    end else if (offCnt_q != 10'h3ff) begin
      offCnt_q <= offCnt_q + 10'h1;
    end
  end

  property p_off_out1; offCnt_q >= 10'h258 |-> !clockOut1; endproperty
  a_off_out1: assert property (p_off_out1)
    else $error("output one toggles while switched off");
  property p_readback_a; rdReq && haddr == 32'h180 |=> hrdata == {24'h0, shadowA_q}; endproperty
  a_readback_a: assert property (p_readback_a)
    else $error("select a reads back a wrong value");
  property p_unmapped_zero; rdReq && haddr == 32'h200 |=> hrdata == 32'h0; endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read returns nonzero data");
  // a short high pulse would mean a switch cut a source mid phase
  property p_runt1; $rose(clockOut1) |=> clockOut1[*3]; endproperty
  a_runt1: assert property (p_runt1)
    else $error("runt high pulse on output one");
  property p_runt2; $rose(clockOut2) |=> clockOut2[*3]; endproperty
  a_runt2: assert property (p_runt2)
    else $error("runt high pulse on output two");
  property p_runt3; $rose(clockOut3) |=> clockOut3[*3]; endproperty
  a_runt3: assert property (p_runt3)
    else $error("runt high pulse on output three");
  property p_runt4; $rose(clockOut4) |=> clockOut4[*3]; endproperty
  a_runt4: assert property (p_runt4)
    else $error("runt high pulse on output four");
  property p_runt5; $rose(clockOut5) |=> clockOut5[*3]; endproperty
  a_runt5: assert property (p_runt5)
    else $error("runt high pulse on output five");
  property p_runt6; $rose(clockOut6) |=> clockOut6[*3]; endproperty
  a_runt6: assert property (p_runt6)
    else $error("runt high pulse on output six");
endmodule

bind ocrs_output_clock_select ocrs_output_clock_select_monitor #(
  .PERIOD_2K_CYC(PERIOD_2K_CYC), .PERIOD_8K_CYC(PERIOD_8K_CYC)
) u_monitor (
  .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .clockOut1(clockOut1), .clockOut2(clockOut2), .clockOut3(clockOut3),
  .clockOut4(clockOut4), .clockOut5(clockOut5), .clockOut6(clockOut6)
);
`default_nettype wire

// *** tb/ocrs_clock_sink.sv ***
`timescale 1ns/1ps
`default_nettype none
module ocrs_clock_sink (
  input  wire logic   clkIn,
  input  wire logic   clr,
  output logic [31:0] periodNs,
  output logic [15:0] edges
);
  realtime lastT;
  logic    seen;

  initial begin
    periodNs = 32'h0;
    edges = 16'h0;
    seen = 1'b0;
    lastT = 0.0;
  end
  // period from the last two rising edges; clr restarts the count
  always @(posedge clkIn or posedge clr) begin
    if (clr) begin
      edges = 16'h0;
      seen = 1'b0;
    end else begin
      if (seen) begin
        periodNs = 32'($rtoi($realtime - lastT));
      end
      lastT = $realtime;
      seen = 1'b1;
      edges = edges + 16'h1;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_output_clock_rate_select.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_output_clock_rate_select
  import ocrs_pkg::*;
  ;
  localparam int  P2K     = 40;
  localparam int  P8K     = 10;
  localparam real MAIN_NS = 82.0;
  localparam real SEC_NS  = 66.0;
  localparam real SYNA_NS = 200.0;
  localparam real SYNB_NS = 300.0;

  logic             core_clk;
  logic             rst_n;
  logic             hsel;
  logic [31:0]      haddr;
  logic [1:0]       htrans;
  logic             hwrite;
  logic [2:0]       hsize;
  logic [31:0]      hwdata;
  wire logic        hreadyout;
  wire logic [31:0] hrdata;
  logic             mainPll;
  logic             secPll;
  logic             synA;
  logic             synB;
  logic             clr;
  wire logic [5:0]  pins;
  wire logic [31:0] per [6];
  wire logic [15:0] edg [6];
  int               errTotal;
  int               numChecks;

  ocrs_output_clock_select #(.PERIOD_2K_CYC(P2K), .PERIOD_8K_CYC(P8K)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .mainPllClk(mainPll),
    .secPllClk(secPll), .synthRateA(synA), .synthRateB(synB), .clockOut1(pins[0]),
    .clockOut2(pins[1]), .clockOut3(pins[2]), .clockOut4(pins[3]),
    .clockOut5(pins[4]), .clockOut6(pins[5])
  );
  for (genvar g = 0; g < 6; g++) begin : g_sink
    ocrs_clock_sink sink (.clkIn(pins[g]), .clr(clr), .periodNs(per[g]), .edges(edg[g]));
  end

  always #4 core_clk = ~core_clk;
  // sources free-run unrelated to the core clock, as real plls would
  always #41 mainPll = ~mainPll;
  always #33 secPll = ~secPll;
  always #100 synA = ~synA;
  always #150 synB = ~synB;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (errTotal == 0 && numChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // bounded wait for hready at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 64) begin
        errTotal++;
        finish_test();
      end
      @(posedge core_clk);
    end
  endtask
  // one single ahb transfer: address phase, then data phase
  task automatic bus(input logic [31:0] a, input logic w, input logic [2:0] sz,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    htrans <= OCRS_HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  // expected output period in ns for output o at code c
  function automatic real exp_ns(input int o, input logic [3:0] c);
    case (c)
      4'h0: return 0.0;
      4'h1: return P2K * 8.0;
      4'h2: return P8K * 8.0;
      4'h3: return (o == 6) ? 2.0 * MAIN_NS : SYNB_NS;
      4'h4: return SYNA_NS;
      4'h5: return (o == 6) ? MAIN_NS : 48.0 * MAIN_NS;
      4'h6: return 16.0 * MAIN_NS;
      4'h7: return 12.0 * MAIN_NS;
      4'h8: return 8.0 * MAIN_NS;
      4'h9: return 6.0 * MAIN_NS;
      4'ha: return 4.0 * MAIN_NS;
      4'hb: return (o == 4) ? 2.0 * SEC_NS : 64.0 * SEC_NS;
      4'hc: return 48.0 * SEC_NS;
      4'hd: return 16.0 * SEC_NS;
      4'he: return 8.0 * SEC_NS;
      default: return 4.0 * SEC_NS;
    endcase
  endfunction

  // a hang anywhere ends the run through the same verdict
  initial begin
    repeat (95000) @(posedge core_clk);
    errTotal++;
    finish_test();
  end

  initial begin
    logic [31:0] r;
    logic [3:0]  cod [7];
    logic [3:0]  old [7];
    logic [7:0]  rstv [3];
    real         e;
    real         mx;
    int          cyc;
    logic        ok;
    core_clk = 1'b0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = OCRS_HSIZE_WORD;
    hwdata = 32'h0;
    {mainPll, secPll, synA, synB, clr} = 5'h0;
    errTotal = 0;
    numChecks = 0;
    old = '{4'h0, 4'h1, 4'h0, 4'h6, 4'h8, 4'ha, 4'h8};
    rstv = '{8'h01, 8'h86, 8'h8a};
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (int j = 0; j < 3; j++) begin
      bus(32'(32'h180 + 4 * j), 1'b0, OCRS_HSIZE_WORD, 32'h0, r);
      chk($sformatf("select reset %0d", j), r, {24'h0, rstv[j]});
    end
    // a byte write and unmapped accesses leave everything untouched
    bus(32'h180, 1'b1, 3'h0, 32'hff, r);
    bus(32'h200, 1'b1, OCRS_HSIZE_WORD, 32'hff, r);
    bus(32'h180, 1'b0, OCRS_HSIZE_WORD, 32'h0, r);
    chk("select a after byte write", r, 32'h01);
    bus(32'h200, 1'b0, OCRS_HSIZE_WORD, 32'h0, r);
    chk("unmapped read", r, 32'h0);
    // each output walks through every code, neighbours differ by one code
    for (int k = 0; k < 16; k++) begin
      mx = 0.0;
      for (int o = 1; o <= 6; o++) begin
        cod[o] = 4'(k + o);
        if (exp_ns(o, cod[o]) > mx) mx = exp_ns(o, cod[o]);
        if (exp_ns(o, old[o]) > mx) mx = exp_ns(o, old[o]);
      end
      cyc = $rtoi(mx * 3.0 / 8.0) + 700;
      for (int j = 0; j < 3; j++) begin
        bus(32'(32'h180 + 4 * j), 1'b1, OCRS_HSIZE_WORD, {24'h0, cod[2*j+2], cod[2*j+1]}, r);
      end
      for (int j = 0; j < 3; j++) begin
        bus(32'(32'h180 + 4 * j), 1'b0, OCRS_HSIZE_WORD, 32'h0, r);
        chk($sformatf("select %0d", j), r, {24'h0, cod[2*j+2], cod[2*j+1]});
      end
      repeat (cyc) @(posedge core_clk);
      clr <= 1'b1;
      @(posedge core_clk);
      clr <= 1'b0;
      repeat (cyc) @(posedge core_clk);
      // every switch has settled long ago, so no busy flag may stand
      bus(32'h1c0, 1'b0, OCRS_HSIZE_WORD, 32'h0, r);
      chk("status busy", r & 32'h3f00, 32'h0);
      for (int o = 1; o <= 6; o++) begin
        e = exp_ns(o, cod[o]);
        if (cod[o] == 4'h0) begin
          chk($sformatf("out%0d edges when off", o), {16'h0, edg[o-1]}, 32'h0);
          chk($sformatf("out%0d level when off", o), {31'h0, pins[o-1]}, 32'h0);
        end else begin
          ok = (edg[o-1] >= 16'h2) && ($itor(per[o-1]) >= e - 16.0) &&
               ($itor(per[o-1]) <= e + 16.0);
          chk($sformatf("out%0d period code %h", o, cod[o]), {31'h0, ok}, 32'h1);
        end
        old[o] = cod[o];
      end
    end
    finish_test();
  end
endmodule
`default_nettype wire
